// >>> core/conv_cfg_regs.sv
// Configuration register bank for input B, reference, timestamp, lanes and calibration
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps

// Notes on behaviour
// - A 16-bit read/write input-B full-scale code over two indexes resets to 0xa000 and drives input B.
// - The full-scale code maps 0x2000 to 500 mV, 0xa000 to 800 mV and 0xffff to 1000 mV.
// - Reference bypass bit 0 selects the analog supply rail as reference and resets to zero.
// - Timestamp control bit 0 enables the timestamp input receiver and resets to zero.
// - Timestamp control bit 1 selects low-voltage PECL signalling and resets to zero.
// - The four-bit pre-emphasis field is one setting copied to all serial lanes.
// - The pre-emphasis register sits at 0x048, resets to 0x00, with bits 7 to 4 reserved read/write.
// - The low-power background calibration register sits at 0x06e and resets to 0x88.
// - Calibration enable, configuration and software trigger registers reset to 0x01.
// - Calibration status and data come from the calibration hardware, not from a reset value.
// - Calibration data enable and pin configuration registers reset to 0x00.
module conv_cfg_regs
  import conv_cfg_pkg::*;
#(
  parameter int NUM_LANES = 16,
  parameter int PE_W = 4
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [15:0] input_b_fullscale_code,
  output logic [9:0] input_b_fullscale_mv,
  output logic reference_bypass_select,
  output logic timestamp_receiver_enable,
  output logic timestamp_lowvolt_pecl_select,
  output logic [NUM_LANES-1:0][PE_W-1:0] lane_preemphasis,
  output cal_ctrl_t cal_ctrl,
  input wire logic [7:0] cal_state_in,
  input wire logic [7:0] cal_data_in,
  output logic cal_data_wr,
  output logic [7:0] cal_data_wdata
);

  bus_req_t req;
  logic hreadyout_q;
  logic hresp_q;
  logic [31:0] hrdata_q;
  logic [15:0] fs_b_q;
  logic [9:0] fs_mv_q;
  logic [7:0] ref_bypass_q;
  logic [7:0] ts_ctrl_q;
  logic [7:0] lane_pe_q;
  cal_ctrl_t cal_q;
  logic cal_data_wr_q;
  logic [7:0] cal_data_wdata_q;
  logic [NUM_LANES-1:0][PE_W-1:0] lane_pe_out_q;
  logic ref_sel_q;
  logic ts_en_q;
  logic ts_pecl_q;

  ahb_cfg_front u_front (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout_q(hreadyout_q),
    .req(req)
  );

  // Write strobe for one index
  function automatic logic wr_hit(input bus_req_t r, input logic [7:0] idx);
    wr_hit = r.wr && r.mapped && (r.idx == idx);
  endfunction : wr_hit

  // Piecewise code to millivolt conversion
  function automatic logic [9:0] fs_to_mv(input logic [15:0] code);
    logic [15:0] d;
    logic [24:0] lo;
    logic [30:0] hi;
    d = 16'h0000;
    lo = 25'h0000000;
    hi = 31'h00000000;
    if (code >= FS_CODE_MID)
    begin
      d = code - FS_CODE_MID;
      hi = 31'(d) * 31'(FS_HI_SLOPE);
      fs_to_mv = FS_MV_MID + 10'(hi >> FS_HI_SHIFT);
    end
    else if (code >= FS_CODE_MIN)
    begin
      d = code - FS_CODE_MIN;
      lo = 25'(d) * 25'(FS_LO_SLOPE);
      fs_to_mv = FS_MV_MIN + 10'(lo >> FS_LO_SHIFT);
    end
    else
    begin
      d = FS_CODE_MIN - code;
      lo = 25'(d) * 25'(FS_LO_SLOPE);
      fs_to_mv = FS_MV_MIN - 10'(lo >> FS_LO_SHIFT);
    end
  endfunction : fs_to_mv

  // Input-B full-scale code, low byte then high byte
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fs_b_q <= RST_FS_B;
    end
    else
    begin
      // Codes below the recommended minimum are still stored
      if (wr_hit(req, IDX_FS_B_LO))
      begin
        fs_b_q[7:0] <= req.wdata;
      end
      if (wr_hit(req, IDX_FS_B_HI))
      begin
        fs_b_q[15:8] <= req.wdata;
      end
    end
  end

  // Millivolt view of the full-scale setting
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fs_mv_q <= FS_MV_MID;
    end
    else
    begin
      fs_mv_q <= fs_to_mv(fs_b_q);
    end
  end

  // Reference bypass and timestamp control
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_bypass_q <= RST_REF_BYPASS;
      ts_ctrl_q <= RST_TS_CTRL;
    end
    else
    begin
      if (wr_hit(req, IDX_REF_BYPASS))
      begin
        ref_bypass_q <= req.wdata;
      end
      if (wr_hit(req, IDX_TS_CTRL))
      begin
        ts_ctrl_q <= req.wdata;
      end
    end
  end

  // Static control outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_sel_q <= 1'b0;
      ts_en_q <= 1'b0;
      ts_pecl_q <= 1'b0;
    end
    else
    begin
      ref_sel_q <= ref_bypass_q[REF_BYPASS_BIT];
      ts_en_q <= ts_ctrl_q[TS_RECV_EN_BIT];
      ts_pecl_q <= ts_ctrl_q[TS_LVPECL_BIT];
    end
  end

  // Pre-emphasis register, reserved upper bits kept as written
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lane_pe_q <= RST_LANE_PE;
    end
    else if (wr_hit(req, IDX_LANE_PE))
    begin
      lane_pe_q <= req.wdata;
    end
  end

  // One global setting fanned out to each lane
  for (genvar g = 0; g < NUM_LANES; g++)
  begin : g_lane
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        lane_pe_out_q[g] <= '0;
      end
      else
      begin
        lane_pe_out_q[g] <= lane_pe_q[LANE_PE_LSB +: PE_W];
      end
    end
  end

  // Calibration control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cal_q.routing <= RST_ROUTING;
      cal_q.enable <= RST_CAL_EN;
      cal_q.config_b <= RST_CAL_CFG;
      cal_q.pin_cfg <= RST_CAL_PIN;
      cal_q.soft_trig <= RST_CAL_TRIG;
      cal_q.low_power <= RST_LOW_POWER_BACKGROUND_CAL;
      cal_q.data_en <= RST_CAL_DATA_EN;
    end
    else
    begin
      if (wr_hit(req, IDX_ROUTING))
      begin
        cal_q.routing <= req.wdata;
      end
      if (wr_hit(req, IDX_CAL_EN))
      begin
        cal_q.enable <= req.wdata;
      end
      if (wr_hit(req, IDX_CAL_CFG))
      begin
        cal_q.config_b <= req.wdata;
      end
      if (wr_hit(req, IDX_CAL_PIN))
      begin
        cal_q.pin_cfg <= req.wdata;
      end
      if (wr_hit(req, IDX_CAL_TRIG))
      begin
        cal_q.soft_trig <= req.wdata;
      end
      if (wr_hit(req, IDX_LOW_POWER_BACKGROUND_CAL))
      begin
        cal_q.low_power <= req.wdata;
      end
      if (wr_hit(req, IDX_CAL_DATA_EN))
      begin
        cal_q.data_en <= req.wdata;
      end
    end
  end

  // Calibration data writes pass to the calibration hardware
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cal_data_wr_q <= 1'b0;
      cal_data_wdata_q <= 8'h00;
    end
    else
    begin
      cal_data_wr_q <= wr_hit(req, IDX_CAL_DATA);
      if (wr_hit(req, IDX_CAL_DATA))
      begin
        cal_data_wdata_q <= req.wdata;
      end
    end
  end

  // Read data, holes and unmapped addresses give a fixed value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_q <= 32'h00000000;
    end
    else if (req.rd)
    begin
      hrdata_q <= 32'h00000000;
      if (!req.mapped)
      begin
        hrdata_q[7:0] <= HOLE_VALUE;
      end
      else
      begin
        unique case (req.idx)
          IDX_FS_B_LO: hrdata_q[7:0] <= fs_b_q[7:0];
          IDX_FS_B_HI: hrdata_q[7:0] <= fs_b_q[15:8];
          IDX_REF_BYPASS: hrdata_q[7:0] <= ref_bypass_q;
          IDX_TS_CTRL: hrdata_q[7:0] <= ts_ctrl_q;
          IDX_LANE_PE: hrdata_q[7:0] <= lane_pe_q;
          IDX_ROUTING: hrdata_q[7:0] <= cal_q.routing;
          IDX_CAL_EN: hrdata_q[7:0] <= cal_q.enable;
          IDX_CAL_CFG: hrdata_q[7:0] <= cal_q.config_b;
          IDX_CAL_STATE: hrdata_q[7:0] <= cal_state_in;
          IDX_CAL_PIN: hrdata_q[7:0] <= cal_q.pin_cfg;
          IDX_CAL_TRIG: hrdata_q[7:0] <= cal_q.soft_trig;
          IDX_LOW_POWER_BACKGROUND_CAL: hrdata_q[7:0] <= cal_q.low_power;
          IDX_CAL_DATA_EN: hrdata_q[7:0] <= cal_q.data_en;
          IDX_CAL_DATA: hrdata_q[7:0] <= cal_data_in;
          default: hrdata_q[7:0] <= HOLE_VALUE;
        endcase
      end
    end
  end

  // Response is always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hresp_q <= HRESP_OKAY;
    end
    else
    begin
      hresp_q <= HRESP_OKAY;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign input_b_fullscale_code = fs_b_q;
  assign input_b_fullscale_mv = fs_mv_q;
  assign reference_bypass_select = ref_sel_q;
  assign timestamp_receiver_enable = ts_en_q;
  assign timestamp_lowvolt_pecl_select = ts_pecl_q;
  assign lane_preemphasis = lane_pe_out_q;
  assign cal_ctrl = cal_q;
  assign cal_data_wr = cal_data_wr_q;
  assign cal_data_wdata = cal_data_wdata_q;

endmodule : conv_cfg_regs

// >>> core/conv_cfg_pkg.sv
// Package with register map, reset values and bus types of the converter configuration bank
package conv_cfg_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_FS_B_LO = 8'h32;
  localparam logic [7:0] IDX_FS_B_HI = 8'h33;
  localparam logic [7:0] IDX_REF_BYPASS = 8'h38;
  localparam logic [7:0] IDX_TS_CTRL = 8'h3b;
  localparam logic [7:0] IDX_LANE_PE = 8'h48;
  localparam logic [7:0] IDX_ROUTING = 8'h60;
  localparam logic [7:0] IDX_CAL_EN = 8'h61;
  localparam logic [7:0] IDX_CAL_CFG = 8'h62;
  localparam logic [7:0] IDX_CAL_STATE = 8'h6a;
  localparam logic [7:0] IDX_CAL_PIN = 8'h6b;
  localparam logic [7:0] IDX_CAL_TRIG = 8'h6c;
  localparam logic [7:0] IDX_LOW_POWER_BACKGROUND_CAL = 8'h6e;
  localparam logic [7:0] IDX_CAL_DATA_EN = 8'h70;
  localparam logic [7:0] IDX_CAL_DATA = 8'h71;

  // Values after reset
  localparam logic [15:0] RST_FS_B = 16'ha000;
  localparam logic [7:0] RST_REF_BYPASS = 8'h00;
  localparam logic [7:0] RST_TS_CTRL = 8'h00;
  localparam logic [7:0] RST_LANE_PE = 8'h00;
  localparam logic [7:0] RST_ROUTING = 8'h01;
  localparam logic [7:0] RST_CAL_EN = 8'h01;
  localparam logic [7:0] RST_CAL_CFG = 8'h01;
  localparam logic [7:0] RST_CAL_PIN = 8'h00;
  localparam logic [7:0] RST_CAL_TRIG = 8'h01;
  localparam logic [7:0] RST_LOW_POWER_BACKGROUND_CAL = 8'h88;
  localparam logic [7:0] RST_CAL_DATA_EN = 8'h00;

  // Value returned from holes and unmapped addresses
  localparam logic [7:0] HOLE_VALUE = 8'h00;

  // Field positions
  localparam int REF_BYPASS_BIT = 0;
  localparam int TS_RECV_EN_BIT = 0;
  localparam int TS_LVPECL_BIT = 1;
  localparam int LANE_PE_LSB = 0;

  // Full-scale code breakpoints and their millivolt values
  localparam logic [15:0] FS_CODE_MIN = 16'h2000;
  localparam logic [15:0] FS_CODE_MID = 16'ha000;
  localparam logic [9:0] FS_MV_MIN = 10'h1f4;
  localparam logic [9:0] FS_MV_MID = 10'h320;
  // Scale factors: 300 mV over 2^15 codes, 200 mV over 0x5fff codes in 2^21 units
  localparam logic [8:0] FS_LO_SLOPE = 9'h12c;
  localparam int FS_LO_SHIFT = 15;
  localparam logic [14:0] FS_HI_SLOPE = 15'h42ac;
  localparam int FS_HI_SHIFT = 21;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic mapped;
    logic [7:0] idx;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] routing;
    logic [7:0] enable;
    logic [7:0] config_b;
    logic [7:0] pin_cfg;
    logic [7:0] soft_trig;
    logic [7:0] low_power;
    logic [7:0] data_en;
  } cal_ctrl_t;

endpackage : conv_cfg_pkg

// >>> core/ahb_cfg_front.sv
// AHB-Lite slave front end turning bus transfers into register requests
`timescale 1ns/1ps
module ahb_cfg_front
  import conv_cfg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout_q,
  output bus_req_t req
);

  logic pend_q;
  logic wr_q;
  logic mapped_q;
  logic [7:0] idx_q;
  logic take;

  assign take = hsel && hready && (htrans == HTRANS_NONSEQ);

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      mapped_q <= 1'b0;
      idx_q <= 8'h00;
    end
    else if (take)
    begin
      wr_q <= hwrite && (hsize == HSIZE_WORD);
      mapped_q <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
      idx_q <= haddr[9:2];
    end
  end

  // One wait state per transfer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_q <= 1'b0;
      hreadyout_q <= 1'b1;
    end
    else
    begin
      pend_q <= take;
      hreadyout_q <= !take;
    end
  end

  always_comb
  begin
    req.wr = pend_q && wr_q;
    req.rd = pend_q && !wr_q;
    req.mapped = mapped_q;
    req.idx = idx_q;
    req.wdata = hwdata[7:0];
  end

endmodule : ahb_cfg_front

// >>> testbench/conv_cfg_props.sv
// Checker of bus timing and register outputs for the configuration bank
`timescale 1ns/1ps
module conv_cfg_props
  import conv_cfg_pkg::*;
#(
  parameter int NUM_LANES = 16,
  parameter int PE_W = 4
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [15:0] input_b_fullscale_code,
  input wire logic [9:0] input_b_fullscale_mv,
  input wire logic reference_bypass_select,
  input wire logic timestamp_receiver_enable,
  input wire logic timestamp_lowvolt_pecl_select,
  input wire logic [NUM_LANES-1:0][PE_W-1:0] lane_preemphasis,
  input wire cal_ctrl_t cal_ctrl,
  input wire logic [7:0] cal_state_in,
  input wire logic cal_data_wr,
  input wire logic [7:0] cal_data_wdata
);
  logic acc;
  logic wacc;
  logic [7:0] idx;
  assign acc = hsel && hready && htrans == HTRANS_NONSEQ && haddr[31:10] == 22'h0
    && haddr[1:0] == 2'b00;
  assign wacc = acc && hwrite && hsize == HSIZE_WORD;
  assign idx = haddr[9:2];
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wait_state_a: assert property (acc |=> !hreadyout ##1 hreadyout)
    else $error("wait state wrong");
  okay_resp_a: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  code_low_a: assert property (wacc && idx == IDX_FS_B_LO
    |-> ##2 input_b_fullscale_code[7:0] == $past(hwdata[7:0])) else $error("code low byte");
  code_high_a: assert property (wacc && idx == IDX_FS_B_HI
    |-> ##2 input_b_fullscale_code[15:8] == $past(hwdata[7:0])) else $error("code high byte");
  fullscale_map_a: assert property (($past(input_b_fullscale_code) == 16'h2000
    |-> input_b_fullscale_mv == 10'h1f4) and ($past(input_b_fullscale_code) == 16'ha000
    |-> input_b_fullscale_mv == 10'h320) and ($past(input_b_fullscale_code) == 16'hffff
    |-> input_b_fullscale_mv == 10'h3e8)) else $error("millivolt map wrong");
  bypass_follow_a: assert property (wacc && idx == IDX_REF_BYPASS
    |-> ##3 reference_bypass_select == $past(hwdata[0], 2)) else $error("bypass wrong");
  stamp_follow_a: assert property (wacc && idx == IDX_TS_CTRL
    |-> ##3 {timestamp_lowvolt_pecl_select, timestamp_receiver_enable} == $past(hwdata[1:0], 2))
    else $error("timestamp bits wrong");
  lanes_same_a: assert property (lane_preemphasis == {NUM_LANES{lane_preemphasis[0]}})
    else $error("lanes differ");
  reset_vals_a: assert property ($rose(hresetn) |-> input_b_fullscale_code == RST_FS_B
    && cal_ctrl == {RST_ROUTING, RST_CAL_EN, RST_CAL_CFG, RST_CAL_PIN, RST_CAL_TRIG,
    RST_LOW_POWER_BACKGROUND_CAL, RST_CAL_DATA_EN}) else $error("reset values wrong");
  state_read_a: assert property (acc && !hwrite && idx == IDX_CAL_STATE
    |-> ##2 hrdata == {24'h0, $past(cal_state_in)}) else $error("status read wrong");
  hole_read_a: assert property (acc && !hwrite
    && (idx inside {[8'h49:8'h5f], [8'h63:8'h69], 8'h6d, 8'h6f}) |-> ##2 hrdata == 32'h0)
    else $error("hole read not zero");
  data_pulse_a: assert property (wacc && idx == IDX_CAL_DATA
    |-> ##2 cal_data_wr && cal_data_wdata == $past(hwdata[7:0]) ##1 !cal_data_wr)
    else $error("data pulse wrong");
endmodule : conv_cfg_props

bind conv_cfg_regs conv_cfg_props #(.NUM_LANES(NUM_LANES), .PE_W(PE_W)) u_props (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hreadyout,
  .hresp, .hrdata, .input_b_fullscale_code, .input_b_fullscale_mv, .reference_bypass_select,
  .timestamp_receiver_enable, .timestamp_lowvolt_pecl_select, .lane_preemphasis, .cal_ctrl,
  .cal_state_in, .cal_data_wr, .cal_data_wdata
);

// >>> testbench/adc_analog_serdes_config_regs_tb.sv
// Self-checking testbench of the configuration register bank
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t got %h expected %h", $time, (g), (e)); end end
module adc_analog_serdes_config_regs_tb
  import conv_cfg_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] cal_state_in = 8'h00;
  logic [7:0] cal_data_in = 8'h00;
  logic hreadyout, hresp, reference_bypass_select, cal_data_wr;
  logic timestamp_receiver_enable, timestamp_lowvolt_pecl_select;
  logic [31:0] hrdata;
  logic [15:0] input_b_fullscale_code;
  logic [9:0] input_b_fullscale_mv;
  logic [15:0][3:0] lane_preemphasis;
  cal_ctrl_t cal_ctrl;
  logic [7:0] cal_data_wdata;
  logic [7:0] rw_idx [12] = '{IDX_FS_B_LO, IDX_FS_B_HI, IDX_REF_BYPASS, IDX_TS_CTRL, IDX_LANE_PE,
    IDX_ROUTING, IDX_CAL_EN, IDX_CAL_CFG, IDX_CAL_PIN, IDX_CAL_TRIG, IDX_LOW_POWER_BACKGROUND_CAL, IDX_CAL_DATA_EN};
  logic [7:0] rw_rst [12] = '{8'h00, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00,
    8'h01, 8'h88, 8'h00};
  logic [31:0] holes [7] = '{32'h124, 32'h17c, 32'h18c, 32'h1b4, 32'h1bc, 32'h400, 32'h0e1};
  logic [7:0] sh [12];
  logic [31:0] seed = 32'h0001466e;
  logic [31:0] rd;
  logic [31:0] r;
  int n_mismatch = 0;
  int compares = 0;

  conv_cfg_regs #(.NUM_LANES(16), .PE_W(4)) uut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata,
    .hreadyout, .hresp, .hrdata, .input_b_fullscale_code, .input_b_fullscale_mv,
    .reference_bypass_select, .timestamp_receiver_enable, .timestamp_lowvolt_pecl_select,
    .lane_preemphasis, .cal_ctrl, .cal_state_in, .cal_data_in, .cal_data_wr, .cal_data_wdata
  );

  initial forever #2 hclk = ~hclk;

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function logic [31:0] ad(input logic [7:0] i);
    return {22'h0, i, 2'b00};
  endfunction : ad

  function logic [9:0] mv_of(input logic [15:0] c);
    if (c < 16'h2000) return 10'h1f4 - 10'((32'(16'h2000 - c) * 300) >> 15);
    if (c < 16'ha000) return 10'h1f4 + 10'((32'(c - 16'h2000) * 300) >> 15);
    return 10'h320 + 10'((32'(c - 16'ha000) * 17068) >> 21);
  endfunction : mv_of

  task give_verdict();
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1)
    begin
      n_mismatch++;
      give_verdict();
    end
  endtask : wait_ready

  task xfer(input logic wr, input logic [2:0] sz, input logic [31:0] a, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    hsize <= sz;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_ready();
    rd = hrdata;
  endtask : xfer

  task check_ports();
    repeat (2) @(posedge hclk);
    `CHK(input_b_fullscale_code, {sh[1], sh[0]})
    `CHK(input_b_fullscale_mv, mv_of({sh[1], sh[0]}))
    `CHK(reference_bypass_select, sh[2][0])
    `CHK(timestamp_receiver_enable, sh[3][0])
    `CHK(timestamp_lowvolt_pecl_select, sh[3][1])
    for (int j = 0; j < 16; j++) `CHK(lane_preemphasis[j], sh[4][3:0])
    `CHK(cal_ctrl, {sh[5], sh[6], sh[7], sh[8], sh[9], sh[10], sh[11]})
  endtask : check_ports

  task put(input int i, input logic [7:0] d);
    xfer(1'b1, HSIZE_WORD, ad(rw_idx[i]), d);
    sh[i] = d;
    xfer(1'b0, HSIZE_WORD, ad(rw_idx[i]), 8'h00);
    `CHK(rd, {24'h0, d})
    check_ports();
  endtask : put

  task do_reset();
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 12; i++) sh[i] = rw_rst[i];
    check_ports();
    for (int i = 0; i < 12; i++)
    begin
      xfer(1'b0, HSIZE_WORD, ad(rw_idx[i]), 8'h00);
      `CHK(rd, {24'h0, rw_rst[i]})
    end
    $display("test reset done");
  endtask : do_reset

  initial
  begin
    do_reset();
    put(1, 8'h20);
    put(0, 8'h00);
    put(1, 8'hff);
    put(0, 8'hff);
    put(1, 8'h10);
    put(1, 8'ha0);
    put(0, 8'h00);
    $display("test fullscale done");
    for (int k = 0; k < 30; k++)
    begin
      r = rnd();
      put(int'(r % 12), r[15:8]);
    end
    $display("test random done");
    r = rnd();
    cal_state_in <= r[7:0];
    cal_data_in <= r[15:8];
    xfer(1'b1, HSIZE_WORD, ad(IDX_CAL_STATE), ~r[7:0]);
    xfer(1'b0, HSIZE_WORD, ad(IDX_CAL_STATE), 8'h00);
    `CHK(rd, {24'h0, r[7:0]})
    xfer(1'b0, HSIZE_WORD, ad(IDX_CAL_DATA), 8'h00);
    `CHK(rd, {24'h0, r[15:8]})
    xfer(1'b1, HSIZE_WORD, ad(IDX_CAL_DATA), r[23:16]);
    `CHK(cal_data_wr, 1'b1)
    @(posedge hclk);
    `CHK(cal_data_wdata, r[23:16])
    `CHK(cal_data_wr, 1'b0)
    for (int h = 0; h < 7; h++)
    begin
      xfer(1'b1, HSIZE_WORD, holes[h], 8'hff);
      xfer(1'b0, HSIZE_WORD, holes[h], 8'h00);
      `CHK(rd, 32'h0)
    end
    xfer(1'b1, 3'b000, ad(IDX_REF_BYPASS), ~sh[2]);
    check_ports();
    $display("test holes done");
    do_reset();
    give_verdict();
  end
endmodule : adc_analog_serdes_config_regs_tb
